// ---- core/dtc_pkg.sv ----
package dtc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the plain register port
    localparam logic [7:0]  DTC_TIMING_ADDR  = 8'h00;
    localparam logic [7:0]  DTC_CONFIG_ADDR  = 8'h04;
    localparam logic [7:0]  DTC_STATUS_ADDR  = 8'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Timing register field positions
    localparam int          DTC_RFC_HI       = 31;
    localparam int          DTC_RFC_LO       = 25;
    localparam int          DTC_RP_HI        = 24;
    localparam int          DTC_RP_LO        = 22;
    localparam int          DTC_RCD_HI       = 21;
    localparam int          DTC_RCD_LO       = 19;
    localparam int          DTC_WR_HI        = 18;
    localparam int          DTC_WR_LO        = 16;
    localparam int          DTC_RAS_HI       = 15;
    localparam int          DTC_RAS_LO       = 11;
    localparam int          DTC_RC_HI        = 10;
    localparam int          DTC_RC_LO        = 6;
    localparam int          DTC_RRD_HI       = 5;
    localparam int          DTC_RRD_LO       = 3;
    localparam int          DTC_RSVD_BIT     = 2;
    localparam int          DTC_WTR_HI       = 1;
    localparam int          DTC_WTR_LO       = 0;

    // Reset value and writable-bit mask of the timing register
    localparam logic [31:0] DTC_TIMING_RESET = {7'h3F, 3'h7, 3'h7, 3'h7,
                                                5'h1F, 5'h1F, 3'h7, 1'h0, 2'h3};
    localparam logic [31:0] DTC_TIMING_WMASK = 32'hFFFFFFFB;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register bits
    localparam int          DTC_CFG_ENABLE   = 0;
    localparam int          DTC_CFG_UNLOCK   = 1;
    localparam logic [31:0] DTC_CFG_RESET    = 32'h00000000;
    localparam logic [31:0] DTC_CFG_WMASK    = 32'h00000003;

    // Status register field positions
    localparam int          DTC_ST_ACT_LO    = 0;
    localparam int          DTC_ST_RW_LO     = 8;
    localparam int          DTC_ST_RFC       = 16;
    localparam int          DTC_ST_RRD       = 17;
    localparam int          DTC_ST_WTR       = 18;

    ////////////////////////////////////////////////////////////////////////////
    // Banks and counters
    localparam int          DTC_NUM_BANKS    = 8;
    localparam int          DTC_BANK_W       = 3;
    localparam logic [6:0]  DTC_ZERO7        = 7'h00;
    localparam logic [4:0]  DTC_ZERO5        = 5'h00;
    localparam logic [2:0]  DTC_ZERO3        = 3'h0;
    localparam logic [1:0]  DTC_ZERO2        = 2'h0;

    // Commands toward the SDRAM
    typedef enum logic [2:0] {
        DTC_CMD_NOP = 3'b000,
        DTC_CMD_REF = 3'b001,
        DTC_CMD_LMR = 3'b010,
        DTC_CMD_ACT = 3'b011,
        DTC_CMD_PRE = 3'b100,
        DTC_CMD_RD  = 3'b101,
        DTC_CMD_WR  = 3'b110
    } dtc_cmd_t;

    // One-hot bank select, used for every per-bank event
    function automatic logic [DTC_NUM_BANKS-1:0] dtc_bank_sel(
        input logic [DTC_BANK_W-1:0] bank,
        input logic                  hit
    );
        logic [DTC_NUM_BANKS-1:0] sel;
        sel       = '0;
        sel[bank] = hit;
        return sel;
    endfunction

endpackage

// ---- core/dtc_timer_if.sv ----
`timescale 1ns/1ps
interface dtc_timer_if;
    logic [2:0] rp_val;   // Precharge gap field
    logic [2:0] rcd_val;  // Row-to-column field
    logic [2:0] wr_val;   // Write-recovery field
    logic [4:0] ras_val;  // Active-to-precharge field
    logic [4:0] rc_val;   // Row-cycle field
    logic       act;      // Activate issued to this bank
    logic       pre;      // Precharge issued to this bank
    logic       wr;       // Write issued to this bank
    logic       act_ok;   // Activate allowed
    logic       rw_ok;    // Read or write allowed
    logic       pre_ok;   // Precharge allowed
    logic       rp_ok;    // Precharge gap expired

    modport ctrl  (output rp_val, rcd_val, wr_val, ras_val, rc_val, act, pre, wr,
                   input  act_ok, rw_ok, pre_ok, rp_ok);
    modport timer (input  rp_val, rcd_val, wr_val, ras_val, rc_val, act, pre, wr,
                   output act_ok, rw_ok, pre_ok, rp_ok);
endinterface

// ---- core/dtc_bank_timer.sv ----
`timescale 1ns/1ps
module dtc_bank_timer
    import dtc_pkg::*;
(
    input  wire logic  clk,    // Controller clock
    input  wire logic  rst_n,  // Synchronised reset, active low
    dtc_timer_if.timer tif     // Loads, events and expiry flags
);
    logic [2:0] rp_cnt, rcd_cnt, wr_cnt;
    logic [4:0] ras_cnt, rc_cnt;
    logic [2:0] next_rp_cnt, next_rcd_cnt, next_wr_cnt;
    logic [4:0] next_ras_cnt, next_rc_cnt;

    // Load field on event, otherwise count down to zero
    always_comb begin
        next_rp_cnt  = (rp_cnt  != DTC_ZERO3) ? rp_cnt  - 3'h1 : rp_cnt;
        next_rcd_cnt = (rcd_cnt != DTC_ZERO3) ? rcd_cnt - 3'h1 : rcd_cnt;
        next_wr_cnt  = (wr_cnt  != DTC_ZERO3) ? wr_cnt  - 3'h1 : wr_cnt;
        next_ras_cnt = (ras_cnt != DTC_ZERO5) ? ras_cnt - 5'h01 : ras_cnt;
        next_rc_cnt  = (rc_cnt  != DTC_ZERO5) ? rc_cnt  - 5'h01 : rc_cnt;
        if (tif.act) begin
            next_rcd_cnt = tif.rcd_val;
            next_ras_cnt = tif.ras_val;
            next_rc_cnt  = tif.rc_val;
        end
        if (tif.pre) begin
            next_rp_cnt = tif.rp_val;
        end
        if (tif.wr) begin
            next_wr_cnt = tif.wr_val;
        end
    end

    // Counter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_cnt  <= DTC_ZERO3;
            rcd_cnt <= DTC_ZERO3;
            wr_cnt  <= DTC_ZERO3;
            ras_cnt <= DTC_ZERO5;
            rc_cnt  <= DTC_ZERO5;
        end else begin
            rp_cnt  <= next_rp_cnt;
            rcd_cnt <= next_rcd_cnt;
            wr_cnt  <= next_wr_cnt;
            ras_cnt <= next_ras_cnt;
            rc_cnt  <= next_rc_cnt;
        end
    end

    // A zero count means the gap has fully elapsed
    assign tif.rp_ok  = (rp_cnt == DTC_ZERO3);
    assign tif.act_ok = (rp_cnt == DTC_ZERO3) && (rc_cnt == DTC_ZERO5);
    assign tif.rw_ok  = (rcd_cnt == DTC_ZERO3);
    assign tif.pre_ok = (ras_cnt == DTC_ZERO5) && (wr_cnt == DTC_ZERO3);

endmodule // dtc_bank_timer

// ---- core/dtc_top.sv ----
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - refresh/load-mode to refresh/activate waits rfc+1
// - precharge to refresh/activate waits rp+1
// - activate to read/write waits rcd+1
// - last write to precharge waits wr+1
// - changed write-recovery while enabled starts initialization
// - activate to precharge waits ras+1
// - activate to activate waits rc+1
// - activate to other-bank activate waits rrd+1
// - reserved bit two reads zero, ignores writes
// - last write to read waits wtr+1
// - timing writes taken only while unlocked
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic                  ref_clk,    // Controller clock, 20 MHz
    input  wire logic                  reset_n,    // Asynchronous reset, active low
    input  wire logic [7:0]            reg_addr,   // Register byte address
    input  wire logic [31:0]           reg_wdata,  // Register write data
    input  wire logic                  reg_wr,     // Register write strobe
    input  wire logic                  reg_rd,     // Register read strobe
    output logic      [31:0]           reg_rdata,  // Read data, cycle after strobe
    input  wire logic                  cmd_valid,  // Scheduler offers a command
    input  wire dtc_cmd_t              cmd_kind,   // Offered command
    input  wire logic [DTC_BANK_W-1:0] cmd_bank,   // Offered command bank
    output logic                       cmd_ready,  // All gaps for the offer elapsed
    output dtc_cmd_t                   mem_cmd,    // Command sent to SDRAM
    output logic      [DTC_BANK_W-1:0] mem_bank,   // Bank sent to SDRAM
    output logic                       init_start  // Initialization request pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic rst_meta, rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] timing_reg, config_reg, status_word;
    logic [31:0] next_timing_reg, next_config_reg, next_rdata;
    logic        next_init_start;
    logic        timing_wr_hit, timing_take, wr_field_changed;

    assign timing_wr_hit    = reg_wr && (reg_addr == DTC_TIMING_ADDR);
    assign timing_take      = timing_wr_hit && config_reg[DTC_CFG_UNLOCK];
    assign wr_field_changed = reg_wdata[DTC_WR_HI:DTC_WR_LO]
                              != timing_reg[DTC_WR_HI:DTC_WR_LO];

    // Write decode, read mux and the initialization trigger
    always_comb begin
        next_timing_reg = timing_reg;
        next_config_reg = config_reg;
        next_rdata      = 32'h00000000;
        next_init_start = 1'b0;
        if (timing_take) begin
            // Reserved bit kept at zero whatever is written
            next_timing_reg = reg_wdata & DTC_TIMING_WMASK;
            next_init_start = wr_field_changed && config_reg[DTC_CFG_ENABLE];
        end else if (reg_wr && (reg_addr == DTC_CONFIG_ADDR)) begin
            next_config_reg = reg_wdata & DTC_CFG_WMASK;
        end
        if (reg_rd) begin
            if (reg_addr == DTC_TIMING_ADDR) begin
                next_rdata = timing_reg;
            end else if (reg_addr == DTC_CONFIG_ADDR) begin
                next_rdata = config_reg;
            end else if (reg_addr == DTC_STATUS_ADDR) begin
                next_rdata = status_word;
            end else begin
                next_rdata = 32'h00000000; // Unmapped reads as zero
            end
        end
    end

    // Register file flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_reg <= DTC_TIMING_RESET;
            config_reg <= DTC_CFG_RESET;
            reg_rdata  <= 32'h00000000;
            init_start <= 1'b0;
        end else begin
            timing_reg <= next_timing_reg;
            config_reg <= next_config_reg;
            reg_rdata  <= next_rdata;
            init_start <= next_init_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field views
    logic [6:0] rfc_val;
    logic [2:0] rp_val, rcd_val, wr_val, rrd_val;
    logic [4:0] ras_val, rc_val;
    logic [1:0] wtr_val;

    assign rfc_val = timing_reg[DTC_RFC_HI:DTC_RFC_LO];
    assign rp_val  = timing_reg[DTC_RP_HI:DTC_RP_LO];
    assign rcd_val = timing_reg[DTC_RCD_HI:DTC_RCD_LO];
    assign wr_val  = timing_reg[DTC_WR_HI:DTC_WR_LO];
    assign ras_val = timing_reg[DTC_RAS_HI:DTC_RAS_LO];
    assign rc_val  = timing_reg[DTC_RC_HI:DTC_RC_LO];
    assign rrd_val = timing_reg[DTC_RRD_HI:DTC_RRD_LO];
    assign wtr_val = timing_reg[DTC_WTR_HI:DTC_WTR_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Per-bank timers
    logic                     cmd_fire;
    logic [DTC_NUM_BANKS-1:0] act_sel, pre_sel, wr_sel;
    logic [DTC_NUM_BANKS-1:0] act_ok_v, rw_ok_v, pre_ok_v, rp_ok_v;

    assign cmd_fire = cmd_valid && cmd_ready;
    assign act_sel  = dtc_bank_sel(cmd_bank, cmd_fire && (cmd_kind == DTC_CMD_ACT));
    assign pre_sel  = dtc_bank_sel(cmd_bank, cmd_fire && (cmd_kind == DTC_CMD_PRE));
    assign wr_sel   = dtc_bank_sel(cmd_bank, cmd_fire && (cmd_kind == DTC_CMD_WR));

    // One timer per bank so that open rows age independently
    generate
        for (genvar b = 0; b < DTC_NUM_BANKS; b++) begin : g_bank
            dtc_timer_if bif ();

            assign bif.rp_val  = rp_val;
            assign bif.rcd_val = rcd_val;
            assign bif.wr_val  = wr_val;
            assign bif.ras_val = ras_val;
            assign bif.rc_val  = rc_val;
            assign bif.act     = act_sel[b];
            assign bif.pre     = pre_sel[b];
            assign bif.wr      = wr_sel[b];
            assign act_ok_v[b] = bif.act_ok;
            assign rw_ok_v[b]  = bif.rw_ok;
            assign pre_ok_v[b] = bif.pre_ok;
            assign rp_ok_v[b]  = bif.rp_ok;

            dtc_bank_timer u_timer (
                .clk   (ref_clk),
                .rst_n (rst_n),
                .tif   (bif.timer)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Device-wide timers: refresh cycle, activate spacing, write-to-read
    logic [6:0] rfc_cnt, next_rfc_cnt;
    logic [2:0] rrd_cnt, next_rrd_cnt;
    logic [1:0] wtr_cnt, next_wtr_cnt;
    logic       rfc_ok, rrd_ok, wtr_ok, all_rp_ok;

    always_comb begin
        next_rfc_cnt = (rfc_cnt != DTC_ZERO7) ? rfc_cnt - 7'h01 : rfc_cnt;
        next_rrd_cnt = (rrd_cnt != DTC_ZERO3) ? rrd_cnt - 3'h1 : rrd_cnt;
        next_wtr_cnt = (wtr_cnt != DTC_ZERO2) ? wtr_cnt - 2'h1 : wtr_cnt;
        if (cmd_fire && (cmd_kind == DTC_CMD_REF || cmd_kind == DTC_CMD_LMR)) begin
            next_rfc_cnt = rfc_val;
        end
        if (cmd_fire && cmd_kind == DTC_CMD_ACT) begin
            next_rrd_cnt = rrd_val;
        end
        if (cmd_fire && cmd_kind == DTC_CMD_WR) begin
            next_wtr_cnt = wtr_val;
        end
    end

    // Device-wide counter flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rfc_cnt <= DTC_ZERO7;
            rrd_cnt <= DTC_ZERO3;
            wtr_cnt <= DTC_ZERO2;
        end else begin
            rfc_cnt <= next_rfc_cnt;
            rrd_cnt <= next_rrd_cnt;
            wtr_cnt <= next_wtr_cnt;
        end
    end

    assign rfc_ok    = (rfc_cnt == DTC_ZERO7);
    assign rrd_ok    = (rrd_cnt == DTC_ZERO3);
    assign wtr_ok    = (wtr_cnt == DTC_ZERO2);
    assign all_rp_ok = &rp_ok_v;

    ////////////////////////////////////////////////////////////////////////////
    // Admission: a command passes only when every gap it depends on is done
    always_comb begin
        case (cmd_kind)
            DTC_CMD_REF: cmd_ready = rfc_ok && all_rp_ok;
            DTC_CMD_LMR: cmd_ready = rfc_ok && all_rp_ok;
            DTC_CMD_ACT: cmd_ready = rfc_ok && rrd_ok && act_ok_v[cmd_bank];
            DTC_CMD_PRE: cmd_ready = pre_ok_v[cmd_bank];
            DTC_CMD_RD:  cmd_ready = rw_ok_v[cmd_bank] && wtr_ok;
            DTC_CMD_WR:  cmd_ready = rw_ok_v[cmd_bank];
            default:     cmd_ready = 1'b1;
        endcase
    end

    // Status view of the expiry flags
    always_comb begin
        status_word = 32'h00000000;
        status_word[DTC_ST_ACT_LO +: DTC_NUM_BANKS] = act_ok_v;
        status_word[DTC_ST_RW_LO  +: DTC_NUM_BANKS] = rw_ok_v;
        status_word[DTC_ST_RFC] = rfc_ok;
        status_word[DTC_ST_RRD] = rrd_ok;
        status_word[DTC_ST_WTR] = wtr_ok;
    end

    // Issued command register; idle cycles send a no-operation
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_cmd  <= DTC_CMD_NOP;
            mem_bank <= '0;
        end else begin
            mem_cmd  <= cmd_fire ? cmd_kind : DTC_CMD_NOP;
            mem_bank <= cmd_fire ? cmd_bank : mem_bank;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic fire_act, fire_pre, fire_ref, fire_rd, fire_wr;
    assign fire_act = cmd_fire && cmd_kind == DTC_CMD_ACT;
    assign fire_pre = cmd_fire && cmd_kind == DTC_CMD_PRE;
    assign fire_ref = cmd_fire && (cmd_kind == DTC_CMD_REF || cmd_kind == DTC_CMD_LMR);
    assign fire_rd  = cmd_fire && cmd_kind == DTC_CMD_RD;
    assign fire_wr  = cmd_fire && cmd_kind == DTC_CMD_WR;

    refresh_gap_a: assert property (
        ((fire_ref || fire_act) |-> rfc_ok) and (fire_ref |=> rfc_cnt == $past(rfc_val)))
        else $error("refresh spacing broken");
    precharge_gap_a: assert property (
        (fire_act || fire_ref) |-> all_rp_ok || fire_act && rp_ok_v[cmd_bank])
        else $error("precharge gap not honoured");
    row_col_a: assert property ((fire_rd || fire_wr) |-> rw_ok_v[cmd_bank])
        else $error("read or write too soon after activate");
    recovery_a: assert property (
        fire_wr ##1 (fire_pre && mem_bank == cmd_bank) |-> $past(wr_val) == 3'h0)
        else $error("precharge too soon after write");
    init_trigger_a: assert property (
        init_start == $past(timing_take && wr_field_changed && config_reg[DTC_CFG_ENABLE]))
        else $error("initialization not started");
    row_open_a: assert property (fire_pre |-> pre_ok_v[cmd_bank])
        else $error("row closed too early");
    act_cycle_a: assert property (fire_act |-> act_ok_v[cmd_bank] && rrd_ok)
        else $error("activate spacing broken");
    bank_spacing_a: assert property (fire_act |=> rrd_cnt == $past(rrd_val))
        else $error("bank spacing counter not loaded");
    reserved_zero_a: assert property (
        reg_rd && reg_addr == DTC_TIMING_ADDR |=> !reg_rdata[DTC_RSVD_BIT])
        else $error("reserved bit reads one");
    write_read_a: assert property (
        fire_wr |=> wtr_cnt == $past(wtr_val) ##0 (!fire_rd || wtr_val == 2'h0))
        else $error("read too soon after write");
    lock_hold_a: assert property (
        timing_wr_hit && !config_reg[DTC_CFG_UNLOCK] |=> $stable(timing_reg))
        else $error("locked timing register changed");
    hold_back_a: assert property (cmd_valid && !cmd_ready |=> mem_cmd == DTC_CMD_NOP)
        else $error("held command was issued");

    act_then_rd_c: cover property (fire_act ##[1:40] fire_rd);
    wr_then_pre_c: cover property (fire_wr ##[1:40] fire_pre);
    init_c:        cover property (init_start);
    stall_c:       cover property (cmd_valid && !cmd_ready [*3]);

endmodule // dtc_top

// ---- verif/dtc_sdram_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-side memory: tracks open rows and counts commands a real part rejects
module dtc_sdram_model
    import dtc_pkg::*;
(
    input  wire logic                  clk,     // Memory clock
    input  wire logic                  rst_n,   // Reset, active low
    input  wire dtc_cmd_t              mem_cmd, // Command from controller
    input  wire logic [DTC_BANK_W-1:0] mem_bank, // Bank of the command
    output logic      [7:0]            bad_cnt  // Illegal commands seen
);
    logic [DTC_NUM_BANKS-1:0] open_rows; // One bit a bank

    // Refresh with a row still open loses data, so it counts as illegal
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_rows <= '0;
            bad_cnt   <= 8'h00;
        end else begin
            case (mem_cmd)
                DTC_CMD_ACT: begin
                    if (open_rows[mem_bank])
                        bad_cnt <= bad_cnt + 8'h01;
                    open_rows[mem_bank] <= 1'b1;
                end
                DTC_CMD_PRE: open_rows[mem_bank] <= 1'b0;
                DTC_CMD_RD, DTC_CMD_WR: begin
                    if (!open_rows[mem_bank])
                        bad_cnt <= bad_cnt + 8'h01;
                end
                DTC_CMD_REF, DTC_CMD_LMR: begin
                    if (|open_rows)
                        bad_cnt <= bad_cnt + 8'h01;
                end
                default: ;
            endcase
        end
    end
endmodule // dtc_sdram_model

// ---- verif/ddr2_command_timing_config_tb.sv ----
`timescale 1ns/1ps
module ddr2_command_timing_config_tb;
    import dtc_pkg::*;
    logic        ref_clk = 0;
    logic        reset_n = 0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic        cmd_valid = 0;
    dtc_cmd_t    cmd_kind = DTC_CMD_NOP;
    logic [2:0]  cmd_bank = 3'h0;
    logic [31:0] reg_rdata;
    logic        cmd_ready;
    dtc_cmd_t    mem_cmd;
    logic [2:0]  mem_bank;
    logic        init_start;
    logic [7:0]  bad_cnt;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          init_seen = 0;
    int          init_exp = 0;
    int          t_act[8], t_pre[8], t_wrb[8], t_ref, t_any, t_wr;
    logic        rd_d = 0;
    logic [31:0] rd_q[$];
    logic [31:0] cmd_q[$];
    logic [31:0] tim, v;
    logic [31:0] lfsr = 32'h00000024;
    // Sequence keeps the far-side memory legal: rows closed before refresh
    dtc_cmd_t ks[15] = '{DTC_CMD_ACT, DTC_CMD_ACT, DTC_CMD_RD, DTC_CMD_WR, DTC_CMD_RD,
        DTC_CMD_PRE, DTC_CMD_PRE, DTC_CMD_ACT, DTC_CMD_PRE, DTC_CMD_REF, DTC_CMD_REF,
        DTC_CMD_LMR, DTC_CMD_ACT, DTC_CMD_WR, DTC_CMD_PRE};
    logic [2:0] bs[15] = '{0, 1, 0, 1, 1, 0, 1, 0, 0, 0, 0, 0, 2, 2, 2};

    dtc_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
        .cmd_ready(cmd_ready), .mem_cmd(mem_cmd), .mem_bank(mem_bank),
        .init_start(init_start));
    dtc_sdram_model mem (.clk(ref_clk), .rst_n(reset_n), .mem_cmd(mem_cmd),
        .mem_bank(mem_bank), .bad_cnt(bad_cnt));

    ////////////////////////////////////////////////////////////////////////////
    always #25 ref_clk = ~ref_clk;

    // Cycle count and hang guard; worst round is about 200 cycles
    always @(posedge ref_clk) begin
        cyc  <= cyc + 1;
        rd_d <= reg_rd;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic int mx(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register port: one-cycle strobes, read data expected the cycle after
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask

    // Offer a command, count refused edges against the gap worked out here
    task automatic issue(input dtc_cmd_t k, input logic [2:0] b);
        int e, first, n, t;
        e = 0;
        case (k)
            DTC_CMD_REF, DTC_CMD_LMR: begin
                e = t_ref + tim[DTC_RFC_HI:DTC_RFC_LO] + 1;
                for (int i = 0; i < 8; i++)
                    e = mx(e, t_pre[i] + tim[DTC_RP_HI:DTC_RP_LO] + 1);
            end
            DTC_CMD_ACT: begin
                e = mx(t_ref + tim[DTC_RFC_HI:DTC_RFC_LO] + 1,
                       t_pre[b] + tim[DTC_RP_HI:DTC_RP_LO] + 1);
                e = mx(e, t_act[b] + tim[DTC_RC_HI:DTC_RC_LO] + 1);
                e = mx(e, t_any + tim[DTC_RRD_HI:DTC_RRD_LO] + 1);
            end
            DTC_CMD_RD: e = mx(t_act[b] + tim[DTC_RCD_HI:DTC_RCD_LO] + 1,
                               t_wr + tim[DTC_WTR_HI:DTC_WTR_LO] + 1);
            DTC_CMD_WR: e = t_act[b] + tim[DTC_RCD_HI:DTC_RCD_LO] + 1;
            default:    e = mx(t_act[b] + tim[DTC_RAS_HI:DTC_RAS_LO] + 1,
                               t_wrb[b] + tim[DTC_WR_HI:DTC_WR_LO] + 1);
        endcase
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_kind  <= k;
        cmd_bank  <= b;
        @(negedge ref_clk);
        first = cyc + 1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        e = mx(e - first, 0);
        check(32'(n), 32'(e), "gap");
        t = cyc + 1;
        if (k == DTC_CMD_REF || k == DTC_CMD_LMR) t_ref = t;
        if (k == DTC_CMD_ACT) begin
            t_act[b] = t;
            t_any = t;
        end
        if (k == DTC_CMD_PRE) t_pre[b] = t;
        if (k == DTC_CMD_WR) begin
            t_wrb[b] = t;
            t_wr = t;
        end
        cmd_q.push_back(32'({k, b}));
    endtask

    // Output watcher: read data, issued commands and init pulses
    always @(negedge ref_clk) begin
        if (init_start === 1'b1) init_seen++;
        if (rd_d) check(reg_rdata, rd_q.pop_front(), "reg_rdata");
        if (mem_cmd !== DTC_CMD_NOP) begin
            if (!cmd_q.size()) check(32'({mem_cmd, mem_bank}), 32'hFFFFFFFF, "extra");
            else check(32'({mem_cmd, mem_bank}), cmd_q.pop_front(), "mem_cmd");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8; i++) begin
            t_act[i] = -1000;
            t_pre[i] = -1000;
            t_wrb[i] = -1000;
        end
        t_ref = -1000;
        t_any = -1000;
        t_wr  = -1000;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Reset values, locked write, unmapped place
        reg_read(DTC_TIMING_ADDR, DTC_TIMING_RESET);
        reg_read(DTC_CONFIG_ADDR, DTC_CFG_RESET);
        reg_write(DTC_TIMING_ADDR, 32'h00000000);
        reg_write(8'h0C, 32'hFFFFFFFF);
        reg_read(DTC_TIMING_ADDR, DTC_TIMING_RESET);
        reg_read(8'h0C, 32'h00000000);
        reg_write(DTC_CONFIG_ADDR, 32'h00000002);
        // Three rounds of field values: mixed, all zero, random
        for (int r = 0; r < 3; r++) begin
            lfsr = lfsr_next(lfsr);
            v = (r == 0) ? 32'h0AD43255 : (r == 1) ? 32'h00000004 : lfsr;
            // Eight-bank spacing from a 150 ns activate gap and 50 ns clock
            if (r == 0) v[DTC_RRD_HI:DTC_RRD_LO] = 3'((4 * 150 + 2 * 50) / 200 - 1);
            if (v[DTC_RAS_HI:DTC_RAS_LO] < 5'(v[DTC_RCD_HI:DTC_RCD_LO]))
                v[DTC_RAS_HI:DTC_RAS_LO] = 5'(v[DTC_RCD_HI:DTC_RCD_LO]);
            reg_write(DTC_TIMING_ADDR, v);
            tim = v & DTC_TIMING_WMASK;
            reg_read(DTC_TIMING_ADDR, tim);
            for (int i = 0; i < 15; i++)
                issue(ks[i], bs[i]);
            @(posedge ref_clk);
            cmd_valid <= 1'b0;
            repeat (140) @(posedge ref_clk);
        end
        // Write-recovery change only restarts init while enabled and accepted
        reg_write(DTC_CONFIG_ADDR, 32'h00000003);
        tim = tim ^ 32'h00010000;
        reg_write(DTC_TIMING_ADDR, tim);
        init_exp++;
        reg_write(DTC_TIMING_ADDR, tim);
        tim = tim ^ 32'h00000040;
        reg_write(DTC_TIMING_ADDR, tim);
        reg_write(DTC_CONFIG_ADDR, 32'h00000002);
        tim = tim ^ 32'h00020000;
        reg_write(DTC_TIMING_ADDR, tim);
        reg_write(DTC_CONFIG_ADDR, 32'h00000001);
        reg_write(DTC_TIMING_ADDR, tim ^ 32'h00070000);
        reg_read(DTC_TIMING_ADDR, tim);
        repeat (4) @(posedge ref_clk);
        check(32'(init_seen), 32'(init_exp), "init pulses");
        check(32'(bad_cnt), 32'h00000000, "memory protocol");
        // A command that never reaches the memory leaves its note behind
        check(32'(cmd_q.size()), 32'h00000000, "cmds left");
        stop_test();
    end
endmodule // ddr2_command_timing_config_tb
